// file: core/ief_pkg.sv
// Package with offsets, field positions and reset values of the interrupt flag block.
package ief_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] IEF_ADDR_ENABLE_TWO = 8'h00;
	localparam logic [7:0] IEF_ADDR_FLAGS_ONE  = 8'h01;
	localparam logic [7:0] IEF_ADDR_FLAGS_TWO  = 8'h02;
	localparam logic [7:0] IEF_ADDR_IRQ_STATUS = 8'h03;
	localparam logic [7:0] IEF_ADDR_IRQ_ENABLE = 8'h04;
	localparam logic [7:0] IEF_ADDR_IRQ_CLEAR  = 8'h05;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int IEF_BIT_TB1      = 5;
	localparam int IEF_BIT_DT       = 7;
	localparam int IEF_BIT_RTC      = 6;
	localparam int IEF_EXT_PINS     = 4;
	localparam int IEF_STATUS_W     = 7;
	localparam int IEF_ST_RTC       = 4;
	localparam int IEF_ST_DT        = 5;
	localparam int IEF_ST_TB1       = 6;
	localparam logic [7:0] IEF_TWO_ONES_MASK = 8'h1f;
	localparam logic [7:0] IEF_ONE_ONES_MASK = 8'h30;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic       IEF_BIT_RESET      = 1'b0;
	localparam logic [3:0] IEF_EXT_RESET      = 4'h0;
	localparam logic [6:0] IEF_STATUS_RESET   = 7'h00;
	localparam logic [7:0] IEF_RDATA_RESET    = 8'h00;
	localparam logic [2:0] IEF_WARM_EDGES     = 3'h4;
	localparam logic [2:0] IEF_WARM_RESET     = 3'h0;

endpackage : ief_pkg

// file: core/ief_pin_edge.sv
// Pin synchroniser and selectable edge detector for the external interrupt pins.
`timescale 1ns/100ps
module ief_pin_edge
	import ief_pkg::*;
(
	// Clock and reset
	input  logic                    i_mclk,
	input  logic                    i_arst_n,
	// Pins and their settings
	input  logic [IEF_EXT_PINS-1:0] i_pin,
	input  logic [IEF_EXT_PINS-1:0] i_edge_select,
	input  logic [IEF_EXT_PINS-1:0] i_pin_is_irq,
	// Detected edges, one cycle each
	output logic [IEF_EXT_PINS-1:0] o_edge
);

	typedef struct packed {
		logic [IEF_EXT_PINS-1:0] s1;
		logic [IEF_EXT_PINS-1:0] s2;
		logic [IEF_EXT_PINS-1:0] s3;
		logic [IEF_EXT_PINS-1:0] stable;
		logic [IEF_EXT_PINS-1:0] edge_hit;
		logic [2:0]              warm;
	} ief_edge_state_t;

	ief_edge_state_t state;
	ief_edge_state_t next_state;
	logic [IEF_EXT_PINS-1:0] agree;
	logic [IEF_EXT_PINS-1:0] changed;
	logic                    primed;

	// Until the chain holds real pin levels no edge is reported, so an idle-high
	// pin does not look like a rising edge right after reset.
	always_comb begin
		next_state = state;
		next_state.s1 = i_pin;
		next_state.s2 = state.s1;
		next_state.s3 = state.s2;
		primed = (state.warm == IEF_WARM_EDGES);
		agree = ~(state.s2 ^ state.s3);
		changed = agree & (state.s3 ^ state.stable);
		if (!primed) begin
			next_state.warm = state.warm + 3'h1;
			next_state.stable = state.s3;
			next_state.edge_hit = IEF_EXT_RESET;
		end else begin
			next_state.stable = (agree & state.s3) | (~agree & state.stable);
			next_state.edge_hit = changed & i_pin_is_irq &
				~(state.s3 ^ i_edge_select);
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign o_edge = state.edge_hit;

endmodule // ief_pin_edge

// file: core/ief_irq_status.sv
// Sticky event status, its enable mask, write-to-clear and the level interrupt.
`timescale 1ns/100ps
module ief_irq_status
	import ief_pkg::*;
(
	// Clock and reset
	input  logic                    i_mclk,
	input  logic                    i_arst_n,
	// Events and register writes
	input  logic [IEF_STATUS_W-1:0] i_event,
	input  logic                    i_wr_enable,
	input  logic                    i_wr_clear,
	input  logic [IEF_STATUS_W-1:0] i_wdata,
	// State
	output logic [IEF_STATUS_W-1:0] o_status,
	output logic [IEF_STATUS_W-1:0] o_enable,
	output logic                    o_irq
);

	typedef struct packed {
		logic [IEF_STATUS_W-1:0] status;
		logic [IEF_STATUS_W-1:0] enable;
		logic                    irq;
	} ief_status_state_t;

	ief_status_state_t state;
	ief_status_state_t next_state;

	// A new event beats a clear written in the same cycle.
	always_comb begin
		next_state = state;
		if (i_wr_enable) begin
			next_state.enable = i_wdata;
		end
		if (i_wr_clear) begin
			next_state.status = state.status & ~i_wdata;
		end
		next_state.status = next_state.status | i_event;
		next_state.irq = |(next_state.status & next_state.enable);
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign o_status = state.status;
	assign o_enable = state.enable;
	assign o_irq    = state.irq;

endmodule // ief_irq_status

// file: core/ief_interrupt_enable_flag_regs.sv
// Second interrupt enable register, both request flag registers and their requests.
`timescale 1ns/100ps
module ief_interrupt_enable_flag_regs
	import ief_pkg::*;
(
	// Clock and reset
	input  logic                    i_mclk,
	input  logic                    i_arst_n,

	// Register port
	input  logic [7:0]              i_addr,
	input  logic [7:0]              i_wdata,
	input  logic                    i_wr,
	input  logic                    i_rd,
	output logic [7:0]              o_rdata,

	// Event sources on the system clock
	input  logic                    i_timer_b_one_overflow,
	input  logic                    i_rtc_overflow,
	input  logic                    i_sleep_direct_transition,
	input  logic                    i_direct_transition_on,

	// External interrupt pins and their settings
	input  logic [IEF_EXT_PINS-1:0] i_ext_pin,
	input  logic [IEF_EXT_PINS-1:0] i_ext_pin_edge_select,
	input  logic [IEF_EXT_PINS-1:0] i_ext_pin_is_irq,

	// Enables held in the first enable register
	input  logic                    i_direct_transition_enable,
	input  logic                    i_rtc_enable,
	input  logic [IEF_EXT_PINS-1:0] i_ext_pin_enable,

	// Requests towards the CPU
	output logic                    o_timer_b_one_ovf_req,
	output logic                    o_direct_transition_req,
	output logic                    o_rtc_overflow_req,
	output logic [IEF_EXT_PINS-1:0] o_ext_pin_req,
	output logic                    o_any_req,

	// Summary interrupt
	output logic                    o_irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                    timer_b_one_ovf_enable;
		logic                    direct_transition_flag;
		logic                    rtc_overflow_flag;
		logic [IEF_EXT_PINS-1:0] ext_pin_flag;
		logic                    timer_b_one_ovf_flag;
		logic                    tb1_req;
		logic                    dt_req;
		logic                    rtc_req;
		logic [IEF_EXT_PINS-1:0] ext_req;
		logic                    any_req;
		logic [7:0]              rdata;
	} ief_regs_state_t;

	ief_regs_state_t state;
	ief_regs_state_t next_state;

	logic [IEF_EXT_PINS-1:0] ext_edge;
	logic [IEF_STATUS_W-1:0] irq_status;
	logic [IEF_STATUS_W-1:0] irq_enable;
	logic [IEF_STATUS_W-1:0] event_vec;
	logic                    set_dt;
	logic                    set_rtc;
	logic                    set_tb1;
	logic                    wr_enable_two;
	logic                    wr_flags_one;
	logic                    wr_flags_two;
	logic                    wr_irq_enable;
	logic                    wr_irq_clear;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic hit(input logic       strobe,
	                             input logic [7:0] addr,
	                             input logic [7:0] target);
		hit = strobe && (addr == target);
	endfunction

	// A flag keeps its value unless software writes 0 to it, and an arriving
	// event always wins so a request racing the clear is not lost.
	function automatic logic flag_next(input logic cur,
	                                   input logic wr,
	                                   input logic wbit,
	                                   input logic set);
		logic kept;
		kept = wr ? (cur & wbit) : cur;
		flag_next = kept | set;
	endfunction

	function automatic logic [7:0] read_mux(input logic [7:0]              addr,
	                                        input ief_regs_state_t         st,
	                                        input logic [IEF_STATUS_W-1:0] sts,
	                                        input logic [IEF_STATUS_W-1:0] ena);
		logic [7:0] v;
		v = 8'h00;
		case (addr)
			IEF_ADDR_ENABLE_TWO: begin
				v = IEF_TWO_ONES_MASK;
				v[IEF_BIT_TB1] = st.timer_b_one_ovf_enable;
			end
			IEF_ADDR_FLAGS_ONE: begin
				v = IEF_ONE_ONES_MASK;
				v[IEF_BIT_DT] = st.direct_transition_flag;
				v[IEF_BIT_RTC] = st.rtc_overflow_flag;
				v[IEF_EXT_PINS-1:0] = st.ext_pin_flag;
			end
			IEF_ADDR_FLAGS_TWO: begin
				v = IEF_TWO_ONES_MASK;
				v[IEF_BIT_TB1] = st.timer_b_one_ovf_flag;
			end
			IEF_ADDR_IRQ_STATUS: begin
				v = {1'b0, sts};
			end
			IEF_ADDR_IRQ_ENABLE: begin
				v = {1'b0, ena};
			end
			default: begin
				v = 8'h00;
			end
		endcase
		read_mux = v;
	endfunction

	// ----------------------------------------------------------------
	// Pin edges
	// ----------------------------------------------------------------
	ief_pin_edge u_pin_edge (
		.i_mclk        (i_mclk),
		.i_arst_n      (i_arst_n),
		.i_pin         (i_ext_pin),
		.i_edge_select (i_ext_pin_edge_select),
		.i_pin_is_irq  (i_ext_pin_is_irq),
		.o_edge        (ext_edge)
	);

	// ----------------------------------------------------------------
	// Event decode
	// ----------------------------------------------------------------
	// A SLEEP transition only counts as direct while the control bit is on.
	assign set_dt  = i_sleep_direct_transition & i_direct_transition_on;
	assign set_rtc = i_rtc_overflow;
	assign set_tb1 = i_timer_b_one_overflow;

	assign event_vec = {set_tb1, set_dt, set_rtc, ext_edge};

	assign wr_enable_two = hit(i_wr, i_addr, IEF_ADDR_ENABLE_TWO);
	assign wr_flags_one  = hit(i_wr, i_addr, IEF_ADDR_FLAGS_ONE);
	assign wr_flags_two  = hit(i_wr, i_addr, IEF_ADDR_FLAGS_TWO);
	assign wr_irq_enable = hit(i_wr, i_addr, IEF_ADDR_IRQ_ENABLE);
	assign wr_irq_clear  = hit(i_wr, i_addr, IEF_ADDR_IRQ_CLEAR);

	// ----------------------------------------------------------------
	// Sticky status and summary interrupt
	// ----------------------------------------------------------------
	ief_irq_status u_irq_status (
		.i_mclk      (i_mclk),
		.i_arst_n    (i_arst_n),
		.i_event     (event_vec),
		.i_wr_enable (wr_irq_enable),
		.i_wr_clear  (wr_irq_clear),
		.i_wdata     (i_wdata[IEF_STATUS_W-1:0]),
		.o_status    (irq_status),
		.o_enable    (irq_enable),
		.o_irq       (o_irq)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;

		// Only bit 5 is stored; the reserved bits are never written.
		if (wr_enable_two) begin
			next_state.timer_b_one_ovf_enable = i_wdata[IEF_BIT_TB1];
		end

		next_state.direct_transition_flag = flag_next(state.direct_transition_flag,
			wr_flags_one, i_wdata[IEF_BIT_DT], set_dt);
		next_state.rtc_overflow_flag = flag_next(state.rtc_overflow_flag,
			wr_flags_one, i_wdata[IEF_BIT_RTC], set_rtc);
		for (int i = 0; i < IEF_EXT_PINS; i++) begin
			next_state.ext_pin_flag[i] = flag_next(state.ext_pin_flag[i],
				wr_flags_one, i_wdata[i], ext_edge[i]);
		end
		next_state.timer_b_one_ovf_flag = flag_next(state.timer_b_one_ovf_flag,
			wr_flags_two, i_wdata[IEF_BIT_TB1], set_tb1);

		// Requests follow the new flag and enable values in the same edge,
		// so a disable or a clear drops the request without an extra cycle.
		next_state.tb1_req = next_state.timer_b_one_ovf_flag &
			next_state.timer_b_one_ovf_enable;
		next_state.dt_req = next_state.direct_transition_flag &
			i_direct_transition_enable;
		next_state.rtc_req = next_state.rtc_overflow_flag & i_rtc_enable;
		next_state.ext_req = next_state.ext_pin_flag & i_ext_pin_enable;
		next_state.any_req = next_state.tb1_req | next_state.dt_req |
			next_state.rtc_req | (|next_state.ext_req);

		// Read data stand for exactly one cycle after the read strobe.
		if (i_rd) begin
			next_state.rdata = read_mux(i_addr, state, irq_status, irq_enable);
		end else begin
			next_state.rdata = IEF_RDATA_RESET;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_rdata                 = state.rdata;
	assign o_timer_b_one_ovf_req   = state.tb1_req;
	assign o_direct_transition_req = state.dt_req;
	assign o_rtc_overflow_req      = state.rtc_req;
	assign o_ext_pin_req           = state.ext_req;
	assign o_any_req               = state.any_req;

endmodule // ief_interrupt_enable_flag_regs

// file: dv/ief_interrupt_enable_flag_regs_properties.sv
// Concurrent checks on the ports of the interrupt flag block.
`timescale 1ns/100ps
module ief_properties
	import ief_pkg::*;
(
	// Clock, reset and register port
	input logic                    i_mclk,
	input logic                    i_arst_n,
	input logic [7:0]              i_addr,
	input logic                    i_wr,
	input logic                    i_rd,
	input logic [7:0]              o_rdata,
	// Events and enables
	input logic                    i_timer_b_one_overflow,
	input logic                    i_rtc_overflow,
	input logic                    i_sleep_direct_transition,
	input logic                    i_direct_transition_on,
	input logic                    i_direct_transition_enable,
	input logic                    i_rtc_enable,
	input logic [IEF_EXT_PINS-1:0] i_ext_pin_enable,
	// Requests
	input logic                    o_timer_b_one_ovf_req,
	input logic                    o_direct_transition_req,
	input logic                    o_rtc_overflow_req,
	input logic [IEF_EXT_PINS-1:0] o_ext_pin_req,
	input logic                    o_any_req,
	input logic                    o_irq
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);

	property p_rtc_set;
		i_rtc_overflow && i_rtc_enable |=> o_rtc_overflow_req;
	endproperty
	a_rtc_set: assert property (p_rtc_set) else $error("rtc request missing");
	property p_dt_set;
		i_sleep_direct_transition && i_direct_transition_on && i_direct_transition_enable
			|=> o_direct_transition_req;
	endproperty
	a_dt_set: assert property (p_dt_set) else $error("transition request missing");
	property p_rtc_gate;
		!i_rtc_enable |=> !o_rtc_overflow_req;
	endproperty
	a_rtc_gate: assert property (p_rtc_gate) else $error("rtc request while disabled");
	property p_pin_gate;
		i_ext_pin_enable == 4'h0 |=> o_ext_pin_req == 4'h0;
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("pin request while disabled");
	property p_any;
		o_any_req == (o_timer_b_one_ovf_req | o_direct_transition_req | o_rtc_overflow_req
			| (|o_ext_pin_req));
	endproperty
	a_any: assert property (p_any) else $error("summary request mismatch");
	property p_rd_idle;
		!i_rd |=> o_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
	property p_rd_two;
		i_rd && (i_addr == IEF_ADDR_ENABLE_TWO || i_addr == IEF_ADDR_FLAGS_TWO)
			|=> o_rdata[7:6] == 2'b00 && o_rdata[4:0] == 5'h1f;
	endproperty
	a_rd_two: assert property (p_rd_two) else $error("reserved bits wrong");
	property p_rd_one;
		i_rd && i_addr == IEF_ADDR_FLAGS_ONE |=> o_rdata[5:4] == 2'b11;
	endproperty
	a_rd_one: assert property (p_rd_one) else $error("flag one reserved bits");
	property p_rtc_hold;
		o_rtc_overflow_req && i_rtc_enable && !(i_wr && i_addr == IEF_ADDR_FLAGS_ONE)
			|=> o_rtc_overflow_req;
	endproperty
	a_rtc_hold: assert property (p_rtc_hold) else $error("rtc request dropped");
	property p_tb1_hold;
		o_timer_b_one_ovf_req && !(i_wr && i_addr <= IEF_ADDR_FLAGS_TWO)
			|=> o_timer_b_one_ovf_req;
	endproperty
	a_tb1_hold: assert property (p_tb1_hold) else $error("timer request dropped");

	c_tb1: cover property (i_timer_b_one_overflow ##1 o_timer_b_one_ovf_req);
	c_pin: cover property ($rose(|o_ext_pin_req));
	c_irq: cover property ($fell(o_irq));
endmodule // ief_properties

bind ief_interrupt_enable_flag_regs ief_properties u_props (.i_mclk, .i_arst_n, .i_addr,
	.i_wr, .i_rd, .o_rdata, .i_timer_b_one_overflow, .i_rtc_overflow,
	.i_sleep_direct_transition, .i_direct_transition_on, .i_direct_transition_enable,
	.i_rtc_enable, .i_ext_pin_enable, .o_timer_b_one_ovf_req, .o_direct_transition_req,
	.o_rtc_overflow_req, .o_ext_pin_req, .o_any_req, .o_irq);

// file: dv/ief_cpu_model.sv
// Behavioural CPU core that takes a request whenever its mask bit is clear.
`timescale 1ns/100ps
module ief_cpu_model (
	// Clock and reset
	input  logic       i_mclk,
	input  logic       i_arst_n,
	// Request in, unmask pulse in, count of exceptions taken out
	input  logic       i_any_req,
	input  logic       i_unmask,
	output logic [7:0] o_taken
);
	logic masked;

	// Entry sets the mask again, so one request is taken once.
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			masked <= 1'b1;
			o_taken <= 8'h00;
		end else if (i_any_req && !masked) begin
			masked <= 1'b1;
			o_taken <= o_taken + 8'h01;
		end else if (i_unmask) begin
			masked <= 1'b0;
		end
	end
endmodule // ief_cpu_model

// file: dv/ief_interrupt_enable_flag_regs_tb.sv
// Self-checking testbench of the interrupt enable and flag registers.
`timescale 1ns/100ps
module ief_interrupt_enable_flag_regs_tb;
	import ief_pkg::*;
	logic       i_mclk = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, unmask = 1'b0;
	logic       i_timer_b_one_overflow = 1'b0, i_rtc_overflow = 1'b0;
	logic       i_sleep_direct_transition = 1'b0, i_direct_transition_on = 1'b0;
	logic       i_direct_transition_enable = 1'b0, i_rtc_enable = 1'b0;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, taken;
	logic [3:0] i_ext_pin = 4'hf, i_ext_pin_edge_select = 4'h0;
	logic [3:0] i_ext_pin_is_irq = 4'h0, i_ext_pin_enable = 4'h0, o_ext_pin_req;
	logic       o_timer_b_one_ovf_req, o_direct_transition_req, o_rtc_overflow_req;
	logic       o_any_req, o_irq;
	int         failures = 0, num_checks = 0, cycles = 0;
	logic [7:0] rst_exp [7] = '{8'h1f, 8'h30, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h00};

	always #4 i_mclk = ~i_mclk;

	ief_interrupt_enable_flag_regs uut (.i_mclk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .i_timer_b_one_overflow, .i_rtc_overflow, .i_sleep_direct_transition,
		.i_direct_transition_on, .i_ext_pin, .i_ext_pin_edge_select, .i_ext_pin_is_irq,
		.i_direct_transition_enable, .i_rtc_enable, .i_ext_pin_enable, .o_timer_b_one_ovf_req,
		.o_direct_transition_req, .o_rtc_overflow_req, .o_ext_pin_req, .o_any_req, .o_irq);
	ief_cpu_model u_cpu (.i_mclk, .i_arst_n, .i_any_req(o_any_req), .i_unmask(unmask),
		.o_taken(taken));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	function automatic logic [7:0] exp_one(input logic dt, rtc, input logic [3:0] pins);
		return {dt, rtc, 2'b11, pins};
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [7:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge i_mclk);
		{i_wr, i_addr, i_wdata} <= {1'b1, a, d};
		@(posedge i_mclk);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rdc(input logic [7:0] a, exp, input string name);
		@(posedge i_mclk);
		{i_rd, i_addr} <= {1'b1, a};
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 check(name, o_rdata, exp);
	endtask
	task automatic ev(input logic [2:0] m);
		@(posedge i_mclk);
		{i_sleep_direct_transition, i_rtc_overflow, i_timer_b_one_overflow} <= m;
		@(posedge i_mclk);
		{i_sleep_direct_transition, i_rtc_overflow, i_timer_b_one_overflow} <= 3'b000;
		#1;
	endtask

	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] w;
		logic [3:0] pf;
		logic       s;
		void'($urandom(64031));
		repeat (2) @(posedge i_mclk);
		i_arst_n <= 1'b1;
		for (int k = 0; k < 7; k++) rdc(8'(k), rst_exp[k], "reset");
		repeat (4) begin
			w = 8'($urandom);
			wr(IEF_ADDR_ENABLE_TWO, w);
			rdc(IEF_ADDR_ENABLE_TWO, {2'b00, w[5], 5'h1f}, "enable_two");
		end
		wr(IEF_ADDR_ENABLE_TWO, 8'h20);
		ev(3'b001);
		check("tb1_req", {7'h0, o_timer_b_one_ovf_req}, 8'h01);
		wr(IEF_ADDR_FLAGS_TWO, 8'hff);
		rdc(IEF_ADDR_FLAGS_TWO, 8'h3f, "flags_two");
		wr(IEF_ADDR_ENABLE_TWO, 8'h00);
		check("tb1_off", {7'h0, o_timer_b_one_ovf_req}, 8'h00);
		wr(IEF_ADDR_FLAGS_TWO, 8'h00);
		rdc(IEF_ADDR_FLAGS_TWO, 8'h1f, "flags_two_clr");
		@(posedge i_mclk);
		{i_rtc_enable, i_direct_transition_enable} <= 2'b11;
		ev(3'b100);
		rdc(IEF_ADDR_FLAGS_ONE, 8'h30, "dt_off");
		@(posedge i_mclk);
		i_direct_transition_on <= 1'b1;
		ev(3'b110);
		check("dt_rtc_req", {6'h00, o_direct_transition_req, o_rtc_overflow_req}, 8'h03);
		rdc(IEF_ADDR_FLAGS_ONE, exp_one(1'b1, 1'b1, 4'h0), "dt_rtc");
		// Clear while masked, then clear again unmasked as an event lands.
		wr(IEF_ADDR_FLAGS_ONE, 8'h00);
		@(posedge i_mclk);
		unmask <= 1'b1;
		@(posedge i_mclk);
		{unmask, i_wr, i_addr, i_wdata, i_rtc_overflow} <= {2'b01, IEF_ADDR_FLAGS_ONE, 9'h001};
		@(posedge i_mclk);
		{i_wr, i_rtc_overflow} <= 2'b00;
		rdc(IEF_ADDR_FLAGS_ONE, exp_one(1'b0, 1'b1, 4'h0), "collide");
		check("taken", taken, 8'h01);
		wr(IEF_ADDR_FLAGS_ONE, 8'h00);
		@(posedge i_mclk);
		i_ext_pin_enable <= 4'hf;
		pf = 4'h0;
		for (int p = 0; p < 4; p++) begin
			s = (p < 2) ? p[0] : 1'($urandom);
			@(posedge i_mclk);
			i_ext_pin_edge_select[p] <= s;
			i_ext_pin[p] <= s;
			repeat (8) @(posedge i_mclk);
			i_ext_pin_is_irq[p] <= 1'b1;
			i_ext_pin[p] <= !s;
			repeat (8) @(posedge i_mclk);
			rdc(IEF_ADDR_FLAGS_ONE, exp_one(1'b0, 1'b0, pf), "wrong_edge");
			@(posedge i_mclk);
			i_ext_pin[p] <= s;
			repeat (8) @(posedge i_mclk);
			pf[p] = 1'b1;
			rdc(IEF_ADDR_FLAGS_ONE, exp_one(1'b0, 1'b0, pf), "pin_edge");
			check("pin_req", {4'h0, o_ext_pin_req}, {4'h0, pf});
		end
		wr(IEF_ADDR_IRQ_ENABLE, 8'hff);
		rdc(IEF_ADDR_IRQ_ENABLE, 8'h7f, "irq_enable");
		rdc(IEF_ADDR_IRQ_STATUS, 8'h7f, "irq_status");
		check("irq_on", {7'h0, o_irq}, 8'h01);
		wr(IEF_ADDR_IRQ_ENABLE, 8'h00);
		check("irq_masked", {7'h0, o_irq}, 8'h00);
		wr(IEF_ADDR_IRQ_ENABLE, 8'hff);
		wr(IEF_ADDR_IRQ_CLEAR, 8'h7f);
		check("irq_cleared", {7'h0, o_irq}, 8'h00);
		rdc(IEF_ADDR_IRQ_STATUS, 8'h00, "status_clr");
		tally_and_finish();
	end
endmodule // ief_interrupt_enable_flag_regs_tb
